// ===== inc/timer_pkg.sv
/*
 Shared constants, types and helpers for the timer/PWM/capture block.
 Assumes a single synchronous clock domain and SystemVerilog-2012 tools.
*/
package timer_pkg;
  localparam int CNT_W = 16;
  localparam int PSC_W = 5;
  localparam logic [PSC_W-1:0] PSC_MAX = 5'h10;
  // Mode codes
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_COUNT = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_CAPT = 3'h3;
  localparam logic [2:0] MODE_DS_NRZ = 3'h4;
  localparam logic [2:0] MODE_DS_RTZ = 3'h5;
  // Event edge selection
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] LFSR_SEED = 16'hACE1;
  // Timing
  localparam int CLK_NS = 50;
  localparam int EVENT_MIN_NS = 100;
  localparam int EVENT_MIN_CYC = (EVENT_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} run_e;

  // Low-bit mask for a divide by two to the power n, clamped at 16
  function automatic logic [CNT_W-1:0] div_mask(input logic [PSC_W-1:0] n);
    logic [PSC_W-1:0] m;
    m = (n > PSC_MAX) ? PSC_MAX : n;
    div_mask = 16'hFFFF >> (5'h10 - m);
    if (m == 5'h00) div_mask = 16'h0000;
  endfunction : div_mask

  // Bit reversal used to spread delta-sigma pulses
  function automatic logic [CNT_W-1:0] bitrev16(input logic [CNT_W-1:0] v);
    for (int i = 0; i < CNT_W; i++) bitrev16[i] = v[CNT_W-1-i];
  endfunction : bitrev16
endpackage : timer_pkg

// ===== logic/general_timer_pwm_capture.sv
/*
 Timer channel and top level: one general timer plus pulse-only timers.
 Assumes all inputs synchronous to clk, single-cycle start/stop pulses.
*/
`timescale 1ns/1ps
module timer_channel #(
  parameter bit HAS_EXT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] mode,
  input wire logic single_shot,
  input wire logic [timer_pkg::PSC_W-1:0] prescale,
  input wire logic gate_en,
  input wire logic [1:0] edge_sel,
  input wire logic alt_sel,
  input wire logic out_en,
  input wire logic int_rise_en,
  input wire logic int_fall_en,
  input wire logic [timer_pkg::CNT_W-1:0] rise_val,
  input wire logic [timer_pkg::CNT_W-1:0] fall_val,
  input wire logic cap_read,
  input wire logic gate_std,
  input wire logic gate_alt,
  input wire logic cap_std,
  input wire logic cap_alt,
  output logic [timer_pkg::CNT_W-1:0] count_q,
  output logic [timer_pkg::CNT_W-1:0] rise_q,
  output logic [timer_pkg::CNT_W-1:0] fall_q,
  output logic running_q,
  output logic irq_rise_q,
  output logic irq_fall_q,
  output logic pin_q,
  output logic oe_std_q,
  output logic oe_alt_q
);
  import timer_pkg::*;
  run_e st_q, st_d;
  logic [CNT_W-1:0] psc_q, psc_d, cnt_d, rise_d, fall_d, lfsr_q, lfsr_d;
  logic out_d, ph_q, ph_d, seen_q, seen_d, evp_q, evp_d, capp_q, capp_d;
  logic irq_rise_d, irq_fall_d, oe_std_d, oe_alt_d;
  logic mode_ok, gate_lvl, cap_lvl, ev_hit, tick, hold, adv;
  logic hit_r, hit_f, cap_r, cap_f, pulse_md, ds_md, ds_bit;
  logic [CNT_W-1:0] cnt_inc, mask;
  // Decode of pins, prescaler tick and counter advance
  always_comb begin
    mode_ok = HAS_EXT || (mode != MODE_COUNT && mode != MODE_CAPT);
    gate_lvl = HAS_EXT && (alt_sel ? gate_alt : gate_std);
    cap_lvl = HAS_EXT && (alt_sel ? cap_alt : cap_std);
    // Edge per sample is enough as edges are EVENT_MIN_CYC apart
    ev_hit = (edge_sel[0] && gate_lvl && !evp_q) ||
             (edge_sel[1] && !gate_lvl && evp_q);
    mask = div_mask(prescale);
    tick = (psc_q & mask) == mask;
    hold = gate_en && gate_lvl && mode != MODE_COUNT;
    adv = (st_q == ST_RUN) && !hold &&
          ((mode == MODE_COUNT) ? ev_hit : tick);
    cnt_inc = count_q + 16'h0001;
    pulse_md = (mode == MODE_TIMER) || (mode == MODE_COUNT) ||
               (mode == MODE_PWM);
    ds_md = (mode == MODE_DS_NRZ) || (mode == MODE_DS_RTZ);
    hit_r = adv && pulse_md && (cnt_inc == rise_q);
    hit_f = adv && pulse_md && (cnt_inc == fall_q);
    cap_r = cap_lvl && !capp_q;
    cap_f = !cap_lvl && capp_q;
    ds_bit = (bitrev16(count_q) ^ lfsr_q) < rise_q;
  end

  // Next state of the counter, compare registers and output
  always_comb begin
    st_d = st_q;
    psc_d = (st_q == ST_RUN) ? psc_q + 16'h0001 : CNT_RESET;
    cnt_d = count_q;
    rise_d = rise_q;
    fall_d = fall_q;
    lfsr_d = lfsr_q;
    out_d = pin_q;
    ph_d = ph_q;
    seen_d = seen_q;
    evp_d = gate_lvl;
    capp_d = cap_lvl;
    if (start && mode_ok) begin
      st_d = ST_RUN;
      cnt_d = CNT_RESET;
      psc_d = CNT_RESET;
      rise_d = rise_val;
      fall_d = fall_val;
      out_d = 1'b0;
      ph_d = 1'b0;
      seen_d = 1'b0;
    end else if (stop || !mode_ok) begin
      st_d = ST_IDLE;
      out_d = 1'b0;
    end else if (st_q == ST_RUN) begin
      case (mode)
        MODE_TIMER, MODE_COUNT, MODE_PWM: begin
          if (adv) cnt_d = cnt_inc;
          if (hit_r && mode == MODE_PWM) out_d = 1'b1;
          if (hit_f) begin
            out_d = 1'b0;
            if (single_shot) begin
              st_d = ST_IDLE;
            end else begin
              cnt_d = CNT_RESET;
              rise_d = rise_val;
              fall_d = fall_val;
            end
          end
        end
        MODE_CAPT: begin
          if (adv) cnt_d = cnt_inc;
          if (cap_r) begin
            rise_d = count_q;
            seen_d = 1'b1;
          end
          if (cap_f && seen_q) fall_d = count_q;
          if (cap_read) st_d = ST_IDLE;
        end
        MODE_DS_NRZ, MODE_DS_RTZ: begin
          out_d = ds_bit && (mode == MODE_DS_NRZ || !ph_q);
          if (tick && !hold) begin
            if (mode == MODE_DS_RTZ) ph_d = !ph_q;
            if (mode == MODE_DS_NRZ || ph_q) begin
              cnt_d = cnt_inc;
              if (count_q == 16'hFFFF) begin
                lfsr_d = {lfsr_q[14:0],
                          lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
                rise_d = rise_val;
              end
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    irq_rise_d = hit_r && int_rise_en;
    irq_fall_d = hit_f && int_fall_en;
    // Only PWM and delta-sigma modes drive a pin, timer mode leaves pins free
    oe_std_d = out_en && !alt_sel && (mode == MODE_PWM || ds_md);
    oe_alt_d = out_en && alt_sel && (mode == MODE_PWM || ds_md);
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      psc_q <= CNT_RESET;
      count_q <= CNT_RESET;
      rise_q <= CNT_RESET;
      fall_q <= CNT_RESET;
      lfsr_q <= LFSR_SEED;
      pin_q <= 1'b0;
      ph_q <= 1'b0;
      seen_q <= 1'b0;
      evp_q <= 1'b0;
      capp_q <= 1'b0;
      running_q <= 1'b0;
      irq_rise_q <= 1'b0;
      irq_fall_q <= 1'b0;
      oe_std_q <= 1'b0;
      oe_alt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      psc_q <= psc_d;
      count_q <= cnt_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      lfsr_q <= lfsr_d;
      pin_q <= out_d;
      ph_q <= ph_d;
      seen_q <= seen_d;
      evp_q <= evp_d;
      capp_q <= capp_d;
      running_q <= (st_d == ST_RUN);
      irq_rise_q <= irq_rise_d;
      irq_fall_q <= irq_fall_d;
      oe_std_q <= oe_std_d;
      oe_alt_q <= oe_alt_d;
    end
  end

  // Checks on the channel behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !start && !stop;
  endsequence
  sequence s_pwm_fall;
    s_quiet ##0 (mode == MODE_PWM) && hit_f;
  endsequence
  property p_start_clear;
    start && mode_ok |=> count_q == CNT_RESET && running_q;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("counter not cleared at start");
  property p_gate_hold;
    s_quiet ##0 (st_q == ST_RUN) && hold && pulse_md |=> $stable(count_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("counter moved while gated");
  property p_psc_div;
    s_quiet ##0 tick && prescale != 5'h00 && st_q == ST_RUN ##1
      $stable(prescale) |-> !tick;
  endproperty
  a_psc_div: assert property (p_psc_div)
    else $error("prescaler ticked twice in a row");
  // A second match right after the first keeps the interrupt up
  property p_irq_fall;
    hit_f && int_fall_en |=> irq_fall_q ##1 (!irq_fall_q || $past(hit_f));
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("fall interrupt missing or stuck");
  property p_pwm_rise;
    s_quiet ##0 mode == MODE_PWM && hit_r && !hit_f |=> pin_q;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise)
    else $error("pulse did not rise at rise match");
  property p_pwm_fall;
    s_pwm_fall |=> !pin_q && (single_shot ? !running_q :
      (count_q == CNT_RESET && fall_q == $past(fall_val)));
  endproperty
  a_pwm_fall: assert property (p_pwm_fall)
    else $error("wrong action at fall match");
  property p_hold_cmp;
    s_quiet ##0 mode == MODE_PWM && st_q == ST_RUN && !hit_f |=>
      $stable(rise_q) && $stable(fall_q);
  endproperty
  a_hold_cmp: assert property (p_hold_cmp)
    else $error("compare value changed mid-cycle");
  property p_oe;
    oe_std_q || oe_alt_q |-> $past(out_en) && !(oe_std_q && oe_alt_q);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin driven without enable");
  property p_capt;
    s_quiet ##0 mode == MODE_CAPT && st_q == ST_RUN && cap_r |=>
      rise_q == $past(count_q);
  endproperty
  a_capt: assert property (p_capt)
    else $error("rise capture wrong");
  // A restart one cycle after the read legally clears the counter
  property p_capt_read;
    !start ##0 mode == MODE_CAPT && st_q == ST_RUN && cap_read |=>
      !running_q ##1 ($stable(count_q) || $past(start));
  endproperty
  a_capt_read: assert property (p_capt_read)
    else $error("counter kept running after read");
  property p_rtz;
    s_quiet ##0 mode == MODE_DS_RTZ && st_q == ST_RUN && ph_q |=> !pin_q;
  endproperty
  a_rtz: assert property (p_rtz)
    else $error("no low slot in return-to-zero");
  property p_no_ext;
    !mode_ok |=> !running_q;
  endproperty
  a_no_ext: assert property (p_no_ext)
    else $error("unsupported mode running");
endmodule : timer_channel
// Top: channel 0 is the general timer, the rest are pulse-only
module general_timer_pwm_capture #(
  parameter int NUM_PWM = 4,
  localparam int NCH = NUM_PWM + 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start [NCH],
  input wire logic stop [NCH],
  input wire logic [2:0] mode [NCH],
  input wire logic single_shot [NCH],
  input wire logic [timer_pkg::PSC_W-1:0] prescale [NCH],
  input wire logic gate_en,
  input wire logic [1:0] edge_sel,
  input wire logic alt_sel [NCH],
  input wire logic out_en [NCH],
  input wire logic int_rise_en [NCH],
  input wire logic int_fall_en [NCH],
  input wire logic [timer_pkg::CNT_W-1:0] rise_val [NCH],
  input wire logic [timer_pkg::CNT_W-1:0] fall_val [NCH],
  input wire logic cap_read,
  input wire logic gate_event_input,
  input wire logic gate_event_input_alt,
  input wire logic capture_input,
  input wire logic capture_input_alt,
  output logic [timer_pkg::CNT_W-1:0] count_q [NCH],
  output logic [timer_pkg::CNT_W-1:0] rise_q [NCH],
  output logic [timer_pkg::CNT_W-1:0] fall_q [NCH],
  output logic running_q [NCH],
  output logic irq_rise_q [NCH],
  output logic irq_fall_q [NCH],
  output logic pin_q [NCH],
  output logic oe_std_q [NCH],
  output logic oe_alt_q [NCH]
);
  import timer_pkg::*;
  // One channel per timer; external pins reach channel 0 only
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    timer_channel #(.HAS_EXT(i == 0)) u_ch (
      .clk(clk), .rst(rst), .start(start[i]), .stop(stop[i]),
      .mode(mode[i]), .single_shot(single_shot[i]),
      .prescale(prescale[i]), .gate_en(i == 0 && gate_en),
      .edge_sel(edge_sel), .alt_sel(alt_sel[i]), .out_en(out_en[i]),
      .int_rise_en(int_rise_en[i]), .int_fall_en(int_fall_en[i]),
      .rise_val(rise_val[i]), .fall_val(fall_val[i]),
      .cap_read(i == 0 && cap_read),
      .gate_std(gate_event_input), .gate_alt(gate_event_input_alt),
      .cap_std(capture_input), .cap_alt(capture_input_alt),
      .count_q(count_q[i]), .rise_q(rise_q[i]), .fall_q(fall_q[i]),
      .running_q(running_q[i]), .irq_rise_q(irq_rise_q[i]),
      .irq_fall_q(irq_fall_q[i]), .pin_q(pin_q[i]),
      .oe_std_q(oe_std_q[i]), .oe_alt_q(oe_alt_q[i])
    );
  end
endmodule : general_timer_pwm_capture

// ===== tb/ext_source.sv
/*
 Far-side model: drives the gate/event and capture pins of the general timer.
 Assumes the caller sits at a falling clock edge when a task is entered.
*/
`timescale 1ns/1ps
module ext_source (
  input wire logic clk,
  output logic gate,
  output logic gate_alt,
  output logic cap,
  output logic cap_alt
);
  import timer_pkg::*;
  // The unselected pin shows the inverse level, never a stale copy
  assign gate_alt = ~gate;
  assign cap_alt = ~cap;
  initial begin
    gate = 1'b0;
    cap = 1'b0;
  end
  // Hold the gate pin at a level
  task automatic gate_set(input logic v);
    gate = v;
  endtask : gate_set
  // One high pulse of w cycles, at least EVENT_MIN_CYC, then as many cycles low
  task automatic pulse(input bit on_cap, input int w);
    int n;
    n = (w < EVENT_MIN_CYC) ? EVENT_MIN_CYC : w;
    @(negedge clk);
    if (on_cap) cap = 1'b1;
    else gate = 1'b1;
    repeat (n) @(negedge clk);
    if (on_cap) cap = 1'b0;
    else gate = 1'b0;
    repeat (n) @(negedge clk);
  endtask : pulse
endmodule : ext_source

// ===== tb/general_timer_pwm_capture_tb.sv
/*
 Self-checking bench for the timer, pulse, event and capture channels.
 Assumes the package timer_pkg and the ext_source far-side model.
*/
`timescale 1ns/1ps
module general_timer_pwm_capture_tb;
  import timer_pkg::*;
  localparam int N = 5;
  logic clk, rst, gate_en, cap_read, gev, gev_alt, cap, cap_alt;
  logic [1:0] edge_sel;
  logic start [N], stop [N], single_shot [N], alt_sel [N], out_en [N];
  logic int_rise_en [N], int_fall_en [N], running_q [N], pin_q [N];
  logic irq_rise_q [N], irq_fall_q [N], oe_std_q [N], oe_alt_q [N];
  logic [2:0] mode [N];
  logic [PSC_W-1:0] prescale [N];
  logic [CNT_W-1:0] rise_val [N], fall_val [N], count_q [N];
  logic [CNT_W-1:0] rise_q [N], fall_q [N];
  int fail_count = 0;
  int checked = 0;
  bit seen_fall;

  general_timer_pwm_capture #(.NUM_PWM(N - 1)) i_dut (
    .clk(clk), .rst(rst), .start(start), .stop(stop), .mode(mode),
    .single_shot(single_shot), .prescale(prescale), .gate_en(gate_en),
    .edge_sel(edge_sel), .alt_sel(alt_sel), .out_en(out_en),
    .int_rise_en(int_rise_en), .int_fall_en(int_fall_en),
    .rise_val(rise_val), .fall_val(fall_val), .cap_read(cap_read),
    .gate_event_input(gev), .gate_event_input_alt(gev_alt),
    .capture_input(cap), .capture_input_alt(cap_alt), .count_q(count_q),
    .rise_q(rise_q), .fall_q(fall_q), .running_q(running_q),
    .irq_rise_q(irq_rise_q), .irq_fall_q(irq_fall_q), .pin_q(pin_q),
    .oe_std_q(oe_std_q), .oe_alt_q(oe_alt_q)
  );
  ext_source i_src (.clk(clk), .gate(gev), .gate_alt(gev_alt), .cap(cap),
    .cap_alt(cap_alt));

  // Clock and a sticky record of general-timer fall interrupts
  always #25 clk = ~clk;
  always @(posedge clk) if (irq_fall_q[0] === 1'b1) seen_fall <= 1'b1;

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Program a channel and pulse its start for one cycle
  task automatic go(input int c, input logic [2:0] md, input logic ss,
                    input logic [4:0] ps, input logic [15:0] rv, fv);
    mode[c] = md;
    single_shot[c] = ss;
    prescale[c] = ps;
    rise_val[c] = rv;
    fall_val[c] = fv;
    seen_fall = 1'b0;
    start[c] = 1'b1;
    cyc(1);
    start[c] = 1'b0;
  endtask : go

  task automatic t_pwm();
    alt_sel[1] = 1'b1;
    out_en[1] = 1'b1;
    go(1, MODE_PWM, 1'b0, 5'h00, 16'h0002, 16'h0004);
    rise_val[1] = 16'h0001; // Written mid-cycle
    // Rise match and its one-cycle interrupt are both up here
    cyc(2);
    chk("pin", 1, pin_q[1]);
    chk("irq_rise", 1, irq_rise_q[1]);
    chk("rise_q", 16'h0002, rise_q[1]);
    chk("oe_alt", 1, oe_alt_q[1]);
    chk("oe_std", 0, oe_std_q[1]);
    cyc(2);
    chk("pin", 0, pin_q[1]);
    chk("irq_fall", 1, irq_fall_q[1]);
    chk("count", 0, count_q[1]);
    chk("rise_q", 16'h0001, rise_q[1]);
    cyc(1);
    chk("pin", 1, pin_q[1]);
    stop[1] = 1'b1;
    cyc(1);
    stop[1] = 1'b0;
    cyc(1);
    chk("running", 0, running_q[1]);
    // Single shot: one pulse, then the channel stops at the fall value
    go(1, MODE_PWM, 1'b1, 5'h00, 16'h0001, 16'h0003);
    cyc(2);
    chk("pin", 1, pin_q[1]);
    cyc(2);
    chk("pin", 0, pin_q[1]);
    chk("running", 0, running_q[1]);
    chk("count", 16'h0003, count_q[1]);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_timer();
    int n;
    n = 0;
    go(0, MODE_TIMER, 1'b1, 5'h02, 16'h0000, 16'h0005);
    cyc(1);
    while (running_q[0] !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    // The fall interrupt stands in the cycle the channel goes idle
    chk("count", 16'h0005, count_q[0]);
    chk("irq_fall", 1, irq_fall_q[0]);
    chk("period", 1, n >= 17 && n <= 23);
    chk("oe_std", 0, oe_std_q[0]);
    $display("test timer done");
  endtask : t_timer

  task automatic t_event();
    logic [1:0] es [3] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
    for (int k = 0; k < 3; k++) begin
      edge_sel = es[k];
      go(0, MODE_COUNT, 1'b1, 5'h00, 16'h0000, (k == 2) ? 16'h6 : 16'h3);
      repeat (3) i_src.pulse(1'b0, 2);
      cyc(2);
      chk("running", 0, running_q[0]);
      chk("count", (k == 2) ? 16'h6 : 16'h3, count_q[0]);
      chk("irq_fall", 1, seen_fall);
    end
    $display("test event done");
  endtask : t_event

  task automatic t_gate();
    logic [15:0] a;
    gate_en = 1'b1;
    i_src.gate_set(1'b1);
    go(0, MODE_TIMER, 1'b0, 5'h00, 16'h0000, 16'hFFFF);
    cyc(5);
    chk("count", 0, count_q[0]);
    i_src.gate_set(1'b0);
    cyc(2);
    a = count_q[0];
    cyc(3);
    chk("count", a + 16'h3, count_q[0]);
    gate_en = 1'b0;
    $display("test gate done");
  endtask : t_gate

  task automatic t_capt();
    logic [15:0] f1;
    go(0, MODE_CAPT, 1'b0, 5'h00, 16'h0000, 16'hFFFF);
    i_src.pulse(1'b1, 6);
    chk("width", 16'h6, fall_q[0] - rise_q[0]);
    f1 = fall_q[0];
    i_src.pulse(1'b1, 4);
    chk("width", 16'h4, fall_q[0] - rise_q[0]);
    chk("later", 1, rise_q[0] > f1);
    cap_read = 1'b1;
    cyc(1);
    cap_read = 1'b0;
    cyc(1);
    chk("running", 0, running_q[0]);
    f1 = count_q[0];
    cyc(3);
    chk("frozen", f1, count_q[0]);
    $display("test capture done");
  endtask : t_capt

  task automatic t_refuse();
    go(2, MODE_COUNT, 1'b0, 5'h00, 16'h0000, 16'h0004);
    go(3, MODE_CAPT, 1'b0, 5'h00, 16'h0000, 16'h0004);
    cyc(2);
    chk("running", 0, running_q[2]);
    chk("running", 0, running_q[3]);
    $display("test refuse done");
  endtask : t_refuse

  // Return to zero on a fresh channel: every other slot low, half rate
  task automatic t_rtz();
    go(3, MODE_DS_RTZ, 1'b0, 5'h00, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      chk("rtz_pin", (i % 2 == 0) ? 16'h1 : 16'h0, pin_q[3]);
    end
    chk("count", 16'h0002, count_q[3]);
    $display("test return to zero done");
  endtask : t_rtz

  task automatic t_ds();
    int h;
    h = 0;
    out_en[4] = 1'b1;
    go(4, MODE_DS_NRZ, 1'b0, 5'h00, 16'h0005, 16'h0000);
    // Pin lags the count by one cycle: window covers counts 0 to FFFF
    repeat (65536) begin
      cyc(1);
      h += (pin_q[4] === 1'b1);
    end
    chk("highs", 16'h5, h[15:0]);
    chk("oe_std", 1, oe_std_q[4]);
    $display("test delta sigma done");
  endtask : t_ds

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog sized above the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected done seen timeout");
    stop_test();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    gate_en = 1'b0;
    cap_read = 1'b0;
    edge_sel = EDGE_RISE;
    for (int i = 0; i < N; i++) begin
      start[i] = 1'b0;
      stop[i] = 1'b0;
      mode[i] = MODE_TIMER;
      single_shot[i] = 1'b0;
      prescale[i] = 5'h00;
      alt_sel[i] = 1'b0;
      out_en[i] = 1'b0;
      int_rise_en[i] = 1'b1;
      int_fall_en[i] = 1'b1;
      rise_val[i] = 16'h0000;
      fall_val[i] = 16'hFFFF;
    end
    cyc(4);
    rst = 1'b0;
    t_pwm();
    t_timer();
    t_event();
    t_gate();
    t_capt();
    t_refuse();
    t_rtz();
    t_ds();
    stop_test();
  end
endmodule : general_timer_pwm_capture_tb
